// ### hw/dvrs_stepper.v
// reference target stepper driven by the processor voltage code pins
`timescale 1ns/10ps
`default_nettype none
`include "dvrs_regs.vh"
module dvrs_stepper #(
  parameter SUB_W = 8,
  parameter [SUB_W-1:0] SLOT_CYCLES = `DVRS_SLOT_CYCLES
) (
  input wire i_clock,
  input wire i_rst,
  input wire [4:0] i_voltage_code,
  input wire i_half_step_code_bit,
  input wire i_six_bit_table_select,
  output reg [7:0] o_ref_target,
  output reg [7:0] o_ref_goal,
  output reg o_no_load,
  output wire o_slewing,
  output reg [1:0] o_table_mode,
  output wire o_phase_start
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SLEW = 2'h2;

  reg [SUB_W-1:0] sub;
  reg [2:0] slot;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [5:0] acc_code;
  reg loaded;
  reg [1:0] next_mode;
  reg [7:0] next_ref;
  reg [7:0] step_ref;
  reg accept;
  reg [5:0] new_code;
  wire sample_tick;
  wire half_tick;
  wire mode_changed;
  wire six_mode;
  wire [5:0] code6;
  wire smp_valid;
  wire [5:0] smp_code;

  // ----------------------------------------
  // table decode
  // ----------------------------------------
  function dvrs_is_off;
    input [1:0] mode;
    input [5:0] code;
    begin
      if (mode == `DVRS_MODE_SIX) begin
        dvrs_is_off = (code == `DVRS_OFF_SIX_A) || (code == `DVRS_OFF_SIX_B);
      end else begin
        dvrs_is_off = (code[5:1] == `DVRS_OFF_FIVE);
      end
    end
  endfunction

  // six-bit table wraps: the lowest codes sit at the bottom of the range
  function [7:0] dvrs_decode;
    input [1:0] mode;
    input [5:0] code;
    begin
      case (mode)
        `DVRS_MODE_SIX: begin
          if (code <= `DVRS_SIX_WRAP_LAST) begin
            dvrs_decode = `DVRS_BASE_SIX_WRAP - {2'h0, code};
          end else begin
            dvrs_decode = `DVRS_BASE_SIX - {2'h0, code};
          end
        end
        `DVRS_MODE_FIVE_HI: begin
          dvrs_decode = `DVRS_BASE_FIVE_HI - {2'h0, code[5:1], 1'b0};
        end
        default: begin
          dvrs_decode = `DVRS_BASE_FIVE_LO - {2'h0, code[5:1], 1'b0};
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // table select
  // ----------------------------------------
  always @* begin
    if (i_six_bit_table_select) begin
      next_mode = `DVRS_MODE_SIX;
    end else if (i_half_step_code_bit) begin
      next_mode = `DVRS_MODE_FIVE_HI;
    end else begin
      next_mode = `DVRS_MODE_FIVE_LO;
    end
  end

  assign mode_changed = (next_mode != o_table_mode);
  assign six_mode = (o_table_mode == `DVRS_MODE_SIX);
  assign code6 = {i_voltage_code, i_half_step_code_bit & six_mode};

  // ----------------------------------------
  // phase timing: six slots per switching cycle
  // ----------------------------------------
  assign sample_tick = (sub == SLOT_CYCLES - {{(SUB_W-1){1'b0}}, 1'b1});
  assign o_phase_start = sample_tick && (slot == `DVRS_LAST_SLOT);
  // three slots after the cycle start is half a phase cycle
  assign half_tick = sample_tick && (slot == `DVRS_HALF_SLOT);

  always @(posedge i_clock) begin
    if (i_rst) begin
      sub <= {SUB_W{1'b0}};
      slot <= 3'h0;
    end else if (sample_tick) begin
      sub <= {SUB_W{1'b0}};
      slot <= (slot == `DVRS_LAST_SLOT) ? 3'h0 : slot + 3'h1;
    end else begin
      sub <= sub + {{(SUB_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // six-bit validation
  // ----------------------------------------
  dvrs_sampler #(
    .CODE_W(6),
    .CNT_W(2),
    .MATCH_COUNT(`DVRS_MATCH_COUNT)
  ) u_sampler (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(mode_changed),
    .i_strobe(sample_tick && six_mode),
    .i_code(code6),
    .o_valid(smp_valid),
    .o_code(smp_code)
  );

  // ----------------------------------------
  // code acceptance
  // ----------------------------------------
  always @* begin
    accept = 1'b0;
    new_code = code6;
    if (six_mode) begin
      new_code = smp_code;
      // the processor moves one step at a time, so no slew is needed
      accept = smp_valid && (!loaded || smp_code != acc_code);
    end else begin
      // the goal takes any distance in one go, read once per cycle; the target slews to it once loaded, else jumps
      accept = o_phase_start && (!loaded || code6 != acc_code);
    end
  end

  // ----------------------------------------
  // slewing
  // ----------------------------------------
  always @* begin
    if (o_ref_target < o_ref_goal) begin
      step_ref = o_ref_target + `DVRS_STEP_UNITS;
    end else if (o_ref_target > o_ref_goal) begin
      step_ref = o_ref_target - `DVRS_STEP_UNITS;
    end else begin
      step_ref = o_ref_target;
    end
  end

  always @* begin
    next_state = state;
    next_ref = o_ref_target;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_WAIT, ST_SLEW: begin
        if (half_tick) begin
          next_ref = step_ref;
          next_state = (step_ref == o_ref_goal) ? ST_IDLE : ST_SLEW;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign o_slewing = (state != ST_IDLE);

  always @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
      acc_code <= 6'h00;
      loaded <= 1'b0;
      o_ref_target <= `DVRS_RST_REF;
      o_ref_goal <= `DVRS_RST_REF;
      o_no_load <= `DVRS_RST_NO_LOAD;
      o_table_mode <= `DVRS_MODE_FIVE_LO;
    end else begin
      o_table_mode <= next_mode;
      if (mode_changed) begin
        // a new table means a new scale: reload with a jump
        loaded <= 1'b0;
        state <= ST_IDLE;
      end else if (accept) begin
        acc_code <= new_code;
        loaded <= 1'b1;
        if (dvrs_is_off(o_table_mode, new_code)) begin
          o_no_load <= 1'b1;
          state <= ST_IDLE;
        end else begin
          o_no_load <= 1'b0;
          o_ref_goal <= dvrs_decode(o_table_mode, new_code);
          if (six_mode || !loaded) begin
            o_ref_target <= dvrs_decode(o_table_mode, new_code);
            state <= ST_IDLE;
          end else if (dvrs_decode(o_table_mode, new_code) == o_ref_target) begin
            state <= ST_IDLE;
          end else if (state != ST_SLEW) begin
            state <= ST_WAIT;
          end
        end
      end else begin
        state <= next_state;
        o_ref_target <= next_ref;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/dvrs_regs.vh
// constants for the dynamic voltage code reference stepper
`ifndef DVRS_REGS_VH
`define DVRS_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define DVRS_CLOCK_NS 16'h000A
`define DVRS_PHASE_NS 16'h0BB8
`define DVRS_SAMPLES_PER_PHASE 16'h0006
// phase over clock over samples, held at sub counter width
`define DVRS_SLOT_CYCLES 8'h32
`define DVRS_LAST_SLOT 3'h5
`define DVRS_HALF_SLOT 3'h2
`define DVRS_MATCH_COUNT 2'h3

// ----------------------------------------
// table modes
// ----------------------------------------
`define DVRS_MODE_FIVE_LO 2'h0
`define DVRS_MODE_FIVE_HI 2'h1
`define DVRS_MODE_SIX 2'h2

// ----------------------------------------
// code decode, reference in 12.5 mV units
// ----------------------------------------
`define DVRS_REF_W 8
`define DVRS_STEP_UNITS 8'h01
`define DVRS_BASE_FIVE_LO 8'h7C
`define DVRS_BASE_FIVE_HI 8'h94
`define DVRS_BASE_SIX 8'h95
`define DVRS_BASE_SIX_WRAP 8'h57
`define DVRS_SIX_WRAP_LAST 6'h14
`define DVRS_OFF_SIX_A 6'h3F
`define DVRS_OFF_SIX_B 6'h3E
`define DVRS_OFF_FIVE 5'h1F

// ----------------------------------------
// reset values
// ----------------------------------------
`define DVRS_RST_REF 8'h00
`define DVRS_RST_NO_LOAD 1'h1

`endif

// ### hw/dvrs_sampler.v
// consecutive-match validator for the sampled voltage code
`timescale 1ns/10ps
`default_nettype none
`include "dvrs_regs.vh"
module dvrs_sampler #(
  parameter CODE_W = 6,
  parameter CNT_W = 2,
  parameter [CNT_W-1:0] MATCH_COUNT = `DVRS_MATCH_COUNT
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_clear,
  input wire i_strobe,
  input wire [CODE_W-1:0] i_code,
  output reg o_valid,
  output reg [CODE_W-1:0] o_code
);
  reg [CNT_W-1:0] count;

  // ----------------------------------------
  // match counting
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (i_rst || i_clear) begin
      count <= {CNT_W{1'b0}};
      o_code <= {CODE_W{1'b0}};
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      if (i_strobe) begin
        if (count != {CNT_W{1'b0}} && i_code == o_code) begin
          // saturate so a steady code raises one pulse only
          if (count != MATCH_COUNT) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
          end
          if (count == MATCH_COUNT - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            o_valid <= 1'b1;
          end
        end else begin
          o_code <= i_code;
          count <= {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/dvrs_stepper_asserts.sv
// port assertions for the reference stepper
`timescale 1ns/10ps
`default_nettype none
module dvrs_chk #(
  parameter SUB_W = 8,
  parameter [SUB_W-1:0] SLOT_CYCLES = 8'h32
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [4:0] i_voltage_code,
  input wire logic i_half_step_code_bit,
  input wire logic i_six_bit_table_select,
  input wire logic [7:0] o_ref_target,
  input wire logic [7:0] o_ref_goal,
  input wire logic o_no_load,
  input wire logic o_slewing,
  input wire logic [1:0] o_table_mode,
  input wire logic o_phase_start
);
  // ----
  // phase position and checks
  // ----
  localparam int PH = 6 * SLOT_CYCLES;
  logic [11:0] cnt;
  wire logic [5:0] pins = {i_voltage_code, i_half_step_code_bit};
  // own count, so a wrong period in the design cannot hide
  always_ff @(posedge i_clock) begin
    if (i_rst || o_phase_start) begin
      cnt <= 12'h000;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence slew_move;
    o_table_mode != 2'h2 && $stable(o_table_mode) && $past(o_slewing) && $changed(o_ref_target);
  endsequence
  sequence six_take;
    o_table_mode == 2'h2 && $stable(o_table_mode) && $changed(o_ref_goal);
  endsequence
  a_phase_period: assert property (o_phase_start == (cnt == PH - 1))
    else $error("phase pulse off");
  a_mode_pins: assert property (!$past(i_rst) |-> o_table_mode ==
    ($past(i_six_bit_table_select) ? 2'h2 : {1'b0, $past(i_half_step_code_bit)})) else $error("mode");
  a_six_jump: assert property (o_table_mode == 2'h2 && $changed(o_ref_target) |-> o_ref_target == o_ref_goal)
    else $error("six jump");
  // goal moved one edge back, the third read one edge before that, reads one slot apart
  a_six_settle: assert property (six_take |-> $past(pins, 2) == $past(pins, 2 + SLOT_CYCLES) &&
    $past(pins, 2) == $past(pins, 2 + 2 * SLOT_CYCLES)) else $error("six settle");
  a_step_one: assert property (slew_move |-> o_ref_target - $past(o_ref_target) inside {8'h01, 8'hFF})
    else $error("step size");
  a_step_slot: assert property (slew_move |-> cnt == PH / 2)
    else $error("step slot");
  a_goal_phase: assert property (o_table_mode != 2'h2 && $stable(o_table_mode) && $changed(o_ref_goal)
    |-> $past(o_phase_start)) else $error("goal timing");
  // the step that meets the goal must end the slew at that same edge
  a_slew_stop: assert property (o_slewing |-> o_ref_target != o_ref_goal)
    else $error("slew stop");
  a_noload_hold: assert property ($rose(o_no_load) |-> $stable(o_ref_target) && $stable(o_ref_goal))
    else $error("no load moved");
endmodule
bind dvrs_stepper dvrs_chk #(.SUB_W(SUB_W), .SLOT_CYCLES(SLOT_CYCLES)) chk (.i_clock, .i_rst, .i_voltage_code,
  .i_half_step_code_bit, .i_six_bit_table_select, .o_ref_target, .o_ref_goal, .o_no_load, .o_slewing,
  .o_table_mode, .o_phase_start);
`default_nettype wire

// ### test/dvrs_cpu.sv
// processor model driving the code pins
`timescale 1ns/10ps
`default_nettype none
module dvrs_cpu (
  input wire logic [5:0] i_want,
  input wire logic i_six,
  output wire logic [4:0] o_voltage_code,
  output wire logic o_half_step_code_bit,
  output wire logic o_six_bit_table_select
);
  // ----
  // pins
  // ----
  // requests only move just after an edge; six-bit requests are single steps, save the jumps to and from the off codes
  assign o_voltage_code = i_want[5:1];
  assign o_half_step_code_bit = i_want[0];
  assign o_six_bit_table_select = i_six;
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the reference stepper
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic six = 1'b0;
  logic [5:0] want = 6'h00;
  logic [4:0] code;
  logic half, sel, no_load, slewing, phase_start;
  logic [7:0] ref_target, goal;
  logic [1:0] mode;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  dvrs_cpu cpu (.i_want(want), .i_six(six), .o_voltage_code(code), .o_half_step_code_bit(half),
    .o_six_bit_table_select(sel));
  // short slots keep a phase at 12 clocks
  dvrs_stepper #(.SLOT_CYCLES(8'h02)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_voltage_code(code),
    .i_half_step_code_bit(half), .i_six_bit_table_select(sel), .o_ref_target(ref_target), .o_ref_goal(goal),
    .o_no_load(no_load), .o_slewing(slewing), .o_table_mode(mode), .o_phase_start(phase_start));
  // ----
  // clock, limit, helpers
  // ----
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task close_out;
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_goal(input logic [7:0] e, input int b);
    for (int i = 0; i < b && goal !== e; i++) begin
      tick(1);
    end
    chk("goal", e, goal);
  endtask
  task slew_step(input logic [7:0] e, input logic [7:0] gap);
    logic [7:0] r;
    logic [7:0] i;
    r = ref_target;
    for (i = 8'h00; i < 8'h14 && ref_target === r; i++) begin
      tick(1);
    end
    chk("ref", e, ref_target);
    chk("gap", gap, i);
  endtask
  // ----
  // scenarios
  // ----
  task t_six;
    six = 1'b1;
    want = 6'h0A;
    wait_goal(8'h4D, 10);
    chk("ref", 8'h4D, ref_target);
    chk("mode", 8'h02, 8'(mode));
    want = 6'h09;
    wait_goal(8'h4E, 10);
    chk("ref", 8'h4E, ref_target);
    want = 6'h08;
    tick(3);
    want = 6'h07;
    tick(4);
    chk("goal", 8'h4E, goal);
    wait_goal(8'h50, 10);
    for (int k = 0; k < 2; k++) begin
      want = {5'h1F, !k[0]};
      tick(12);
      chk("no_load", 8'h01, 8'(no_load));
      chk("ref", 8'h50, ref_target);
      want = 6'h07;
      tick(12);
      chk("no_load", 8'h00, 8'(no_load));
    end
  endtask
  task t_five;
    six = 1'b0;
    want = {5'h0E, 1'b0};
    wait_goal(8'h60, 30);
    chk("ref", 8'h60, ref_target);
    chk("mode", 8'h00, 8'(mode));
    want = {5'h0C, 1'b0};
    wait_goal(8'h64, 14);
    slew_step(8'h61, 8'h06);
    for (int k = 2; k < 5; k++) begin
      slew_step(8'h60 + 8'(k), 8'h0C);
    end
    tick(2);
    chk("slewing", 8'h00, 8'(slewing));
    want = {5'h10, 1'b1};
    wait_goal(8'h74, 30);
    chk("mode", 8'h01, 8'(mode));
    want = 6'h3F;
    tick(14);
    chk("no_load", 8'h01, 8'(no_load));
    chk("ref", 8'h74, ref_target);
  endtask
  initial begin
    tick(6);
    i_rst = 1'b0;
    tick(1);
    chk("no_load", 8'h01, 8'(no_load));
    chk("ref", 8'h00, ref_target);
    t_six;
    t_five;
    close_out;
  end
endmodule
`default_nettype wire
